// ---- include/ueh_consts.svh ----
// Register offsets, field positions and reset values of the endpoint handshake block
`ifndef UEH_CONSTS_SVH
`define UEH_CONSTS_SVH
// ==========================================
// Register byte offsets
`define UEH_OFS_CTRL0 5'h10
`define UEH_OFS_CTRL1 5'h14
`define UEH_OFS_CLR 5'h18
`define UEH_OFS_FLAGS 5'h1c
// ==========================================
// Control register fields (stall and force-resume used in ctrl1 only, receive enable in ctrl0 only)
`define UEH_B_TOGGLE 7
`define UEH_B_STALL 6
`define UEH_B_TXEN 5
`define UEH_B_RXEN 4
`define UEH_B_FRES 4
`define UEH_CNT_HI 3
// ==========================================
// Flag and clear-strobe bit positions
`define UEH_F_EOP 7
`define UEH_F_BRST 6
`define UEH_F_EP2TX 5
`define UEH_F_EP2RX 4
`define UEH_F_EP1TX 3
`define UEH_F_RESUME 2
`define UEH_F_EP0TX 1
`define UEH_F_EP0RX 0
// ==========================================
// Reset values
`define UEH_RST_CTRL 8'h00
`define UEH_RST_FLAGS 8'h00
`define UEH_RD_ZERO 32'h0000_0000
`endif

// ---- include/ueh_pkg.sv ----
// Types shared by the endpoint handshake block
package ueh_pkg;
  // Token kinds reported by the serial engine
  typedef enum logic [1:0] {
    UEH_TOK_OUT,
    UEH_TOK_IN,
    UEH_TOK_SETUP,
    UEH_TOK_OTHER
  } ueh_tok_t;
  // Reply chosen for a token
  typedef enum logic [2:0] {
    UEH_RSP_NONE,
    UEH_RSP_DATA,
    UEH_RSP_ACK,
    UEH_RSP_NAK,
    UEH_RSP_STALL
  } ueh_rsp_t;
endpackage

// ---- design/ueh_ctrl.sv ----
// Endpoint flow-control, status flags and register slave
`timescale 1ns/1ps
`default_nettype none
`include "ueh_consts.svh"

module ueh_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Token from serial engine, one-cycle pulse
  input wire logic tok_valid,
  input wire logic [1:0] tok_kind,
  input wire logic [1:0] tok_ep,
  // Handshake completion events from serial engine
  input wire logic tx_acked,
  input wire logic [1:0] tx_acked_ep,
  input wire logic rx_acked,
  input wire logic [1:0] rx_acked_ep,
  input wire logic eop_seen,
  input wire logic bus_reset_seen,
  input wire logic bus_activity,
  // Settings held outside this block
  input wire logic ep1_active,
  input wire logic ep2_tx_enable,
  input wire logic ep2_rx_enable,
  input wire logic ep2_tx_data_toggle,
  input wire logic [3:0] ep2_tx_byte_count,
  input wire logic suspend_request,
  // Reply to the token
  output logic rsp_valid,
  output logic [2:0] rsp_kind,
  output logic rsp_toggle,
  output logic [3:0] rsp_count,
  // Line control
  output logic drive_k,
  output logic xcvr_low_power
);

  // ==========================================
  // Reset release
  logic rst_meta_r; // First stage, read only by second
  logic rst_sync_n_r; // Synchronised reset, active low
  wire rst_n = rst_sync_n_r; // Copy that every other process resets on
  // Assert at once, release two edges later
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // ==========================================
  // Reply functions
  // IN reply of a plain endpoint: data only when enabled and idle
  function automatic logic [2:0] in_reply(input logic en, input logic done);
    if (!en || done) begin
      in_reply = 3'(ueh_pkg::UEH_RSP_NAK);
    end else begin
      in_reply = 3'(ueh_pkg::UEH_RSP_DATA);
    end
  endfunction

  // OUT reply: accept only into a free, enabled buffer
  function automatic logic [2:0] out_reply(input logic en, input logic done);
    if (!en || done) begin
      out_reply = 3'(ueh_pkg::UEH_RSP_NAK);
    end else begin
      out_reply = 3'(ueh_pkg::UEH_RSP_ACK);
    end
  endfunction

  // ==========================================
  // Register state
  logic [7:0] ctrl0_r; // Endpoint 0 control
  logic [7:0] ctrl1_r; // Endpoint 1 control
  logic [7:0] flags_r; // Event flags
  logic [7:0] flags_nxt;
  logic wait_r; // Waitrequest flop
  logic [31:0] rdata_r; // Read data flop

  // ==========================================
  // Bus decode
  wire bus_req = avs_read | avs_write;
  wire acc_go = bus_req & ~wait_r; // Cycle in which access completes
  wire wr_go = avs_write & acc_go;
  wire sel_c0 = avs_address == `UEH_OFS_CTRL0;
  wire sel_c1 = avs_address == `UEH_OFS_CTRL1;
  wire sel_clr = avs_address == `UEH_OFS_CLR;
  wire sel_fl = avs_address == `UEH_OFS_FLAGS;
  // Clear strobes exist only in the completing write cycle
  wire [7:0] clr_stb = (wr_go & sel_clr) ? avs_writedata[7:0] : 8'h00;

  // Read mux; clear register and holes read zero
  wire [7:0] rd_byte = sel_c0 ? ctrl0_r :
                       sel_c1 ? ctrl1_r :
                       sel_fl ? flags_r : 8'h00;
  wire [31:0] rd_word = {24'h00_0000, rd_byte};

  // One wait state: waitrequest drops the cycle after a request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= `UEH_RD_ZERO;
    end else begin
      wait_r <= ~(bus_req & wait_r);
      if (avs_read && wait_r) begin
        rdata_r <= rd_word;
      end
    end
  end

  // ==========================================
  // Control registers; full byte written to ctrl1, ctrl0 bit 6 forced to zero, count included
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_r <= `UEH_RST_CTRL;
      ctrl1_r <= `UEH_RST_CTRL;
    end else begin
      if (wr_go && sel_c0) begin
        ctrl0_r <= {avs_writedata[7], 1'b0, avs_writedata[5:0]};
      end
      if (wr_go && sel_c1) begin
        ctrl1_r <= avs_writedata[7:0];
      end
    end
  end

  // Named fields
  wire ep0_tx_enable = ctrl0_r[`UEH_B_TXEN];
  wire ep0_rx_enable = ctrl0_r[`UEH_B_RXEN];
  wire ep1_tx_enable = ctrl1_r[`UEH_B_TXEN];
  wire ep1_force_stall = ctrl1_r[`UEH_B_STALL];
  wire force_remote_wakeup = ctrl1_r[`UEH_B_FRES];

  // ==========================================
  // Flag set events
  wire tx0 = tx_acked & (tx_acked_ep == 2'd0);
  wire tx1 = tx_acked & (tx_acked_ep == 2'd1);
  wire tx2 = tx_acked & (tx_acked_ep == 2'd2);
  wire rx0 = rx_acked & (rx_acked_ep == 2'd0);
  wire rx2 = rx_acked & (rx_acked_ep == 2'd2);
  // Own forced K must not look like host activity
  wire res_set = bus_activity & suspend_request & ~force_remote_wakeup;
  wire [7:0] flag_set = {eop_seen, bus_reset_seen, tx2, rx2, tx1, res_set, tx0, rx0};

  // Set wins over a clear in the same cycle; no write path exists
  assign flags_nxt = flag_set | (flags_r & ~clr_stb);

  // Flag register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= `UEH_RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  wire ep0_tx_done_flag = flags_r[`UEH_F_EP0TX];
  wire ep0_rx_done_flag = flags_r[`UEH_F_EP0RX];
  wire ep1_tx_done_flag = flags_r[`UEH_F_EP1TX];
  wire ep2_tx_done_flag = flags_r[`UEH_F_EP2TX];
  wire ep2_rx_done_flag = flags_r[`UEH_F_EP2RX];
  wire resume_seen_flag = flags_r[`UEH_F_RESUME];

  // ==========================================
  // Token reply decision
  wire is_in = tok_kind == 2'(ueh_pkg::UEH_TOK_IN);
  wire is_out = tok_kind == 2'(ueh_pkg::UEH_TOK_OUT);
  wire is_setup = tok_kind == 2'(ueh_pkg::UEH_TOK_SETUP);
  logic [2:0] rsp_nxt;
  logic tog_nxt;
  logic [3:0] cnt_nxt;

  // Pick reply, toggle and count per endpoint
  always_comb begin
    rsp_nxt = 3'(ueh_pkg::UEH_RSP_NONE);
    tog_nxt = 1'b0;
    cnt_nxt = 4'h0;
    case (tok_ep)
      2'd0: begin
        tog_nxt = ctrl0_r[`UEH_B_TOGGLE];
        cnt_nxt = ctrl0_r[`UEH_CNT_HI:0];
        if (is_in) begin
          rsp_nxt = in_reply(ep0_tx_enable, ep0_tx_done_flag);
        end else if (is_out) begin
          rsp_nxt = out_reply(ep0_rx_enable, ep0_rx_done_flag);
        end else if (is_setup) begin
          // Setup is always taken, whatever the flag
          rsp_nxt = 3'(ueh_pkg::UEH_RSP_ACK);
        end
      end
      2'd1: begin
        tog_nxt = ctrl1_r[`UEH_B_TOGGLE];
        cnt_nxt = ctrl1_r[`UEH_CNT_HI:0];
        if (ep1_force_stall && (is_in || is_out)) begin
          rsp_nxt = 3'(ueh_pkg::UEH_RSP_STALL);
        end else if (is_in && ep1_active) begin
          // Inactive endpoint stays silent unless a stall is forced
          rsp_nxt = in_reply(ep1_tx_enable, ep1_tx_done_flag);
        end
      end
      2'd2: begin
        tog_nxt = ep2_tx_data_toggle;
        cnt_nxt = ep2_tx_byte_count;
        if (is_in) begin
          rsp_nxt = in_reply(ep2_tx_enable, ep2_tx_done_flag);
        end else if (is_out) begin
          rsp_nxt = out_reply(ep2_rx_enable, ep2_rx_done_flag);
        end
      end
      default: begin
        // Unknown endpoint: no reply
        rsp_nxt = 3'(ueh_pkg::UEH_RSP_NONE);
      end
    endcase
  end

  // ==========================================
  // Reply and line-control outputs
  logic rsp_valid_r;
  logic [2:0] rsp_kind_r;
  logic rsp_toggle_r;
  logic [3:0] rsp_count_r;
  logic drive_k_r;
  logic low_pwr_r;

  // Reply stands one cycle after the token
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_r <= 1'b0;
      rsp_kind_r <= 3'(ueh_pkg::UEH_RSP_NONE);
      rsp_toggle_r <= 1'b0;
      rsp_count_r <= 4'h0;
      drive_k_r <= 1'b0;
      low_pwr_r <= 1'b0;
    end else begin
      rsp_valid_r <= tok_valid;
      if (tok_valid) begin
        rsp_kind_r <= rsp_nxt;
        rsp_toggle_r <= tog_nxt;
        rsp_count_r <= cnt_nxt;
      end
      drive_k_r <= force_remote_wakeup;
      low_pwr_r <= suspend_request;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_kind = rsp_kind_r;
  assign rsp_toggle = rsp_toggle_r;
  assign rsp_count = rsp_count_r;
  assign drive_k = drive_k_r;
  assign xcvr_low_power = low_pwr_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  wire t0 = tok_valid & (tok_ep == 2'd0);
  wire t1 = tok_valid & (tok_ep == 2'd1);
  wire t2 = tok_valid & (tok_ep == 2'd2);
  wire [7:0] set_clr_hit = flag_set & clr_stb; // Same-cycle set and clear per flag

  property p_in_nak;
    t0 && is_in && (!ep0_tx_enable || ep0_tx_done_flag)
      |=> rsp_valid && rsp_kind == 3'(ueh_pkg::UEH_RSP_NAK);
  endproperty
  a_in_nak: assert property (p_in_nak) else $error("IN not NAKed");
  property p_in_data;
    t0 && is_in && ep0_tx_enable && !ep0_tx_done_flag
      |=> rsp_kind == 3'(ueh_pkg::UEH_RSP_DATA) && rsp_toggle == $past(ctrl0_r[7]);
  endproperty
  a_in_data: assert property (p_in_data) else $error("IN data wrong");
  property p_ep1_force_stall;
    t1 && (is_in || is_out) && ep1_force_stall |=> rsp_kind == 3'(ueh_pkg::UEH_RSP_STALL);
  endproperty
  a_ep1_force_stall: assert property (p_ep1_force_stall) else $error("No stall on ep1");
  property p_out2;
    t2 && is_out && (ep2_rx_done_flag || !ep2_rx_enable)
      |=> rsp_kind == 3'(ueh_pkg::UEH_RSP_NAK);
  endproperty
  a_out2: assert property (p_out2) else $error("Ep2 OUT not NAKed");
  property p_setup;
    t0 && is_setup |=> rsp_kind == 3'(ueh_pkg::UEH_RSP_ACK);
  endproperty
  a_setup: assert property (p_setup) else $error("SETUP refused");
  // Every flag hit by set and clear together must still be set afterwards
  property p_set_wins;
    set_clr_hit != 8'h00 |=> (flags_r & $past(set_clr_hit)) == $past(set_clr_hit);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Event lost to clear");
  property p_no_self_res;
    force_remote_wakeup && !resume_seen_flag && !eop_seen |=> !resume_seen_flag;
  endproperty
  a_no_self_res: assert property (p_no_self_res) else $error("Resume from own K");
  property p_flag_hold;
    ep0_tx_done_flag && !clr_stb[`UEH_F_EP0TX] |=> ep0_tx_done_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag lost");
  property p_clr_zero;
    avs_read && wait_r && sel_clr ##1 !wait_r |-> avs_readdata == `UEH_RD_ZERO;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("Clear reg reads nonzero");
  property p_rx_set;
    rx0 |=> ep0_rx_done_flag;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("Rx flag not set");
  property p_tx_set;
    tx2 |=> ep2_tx_done_flag;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("Tx flag not set");
  property p_res_set;
    res_set |=> resume_seen_flag;
  endproperty
  a_res_set: assert property (p_res_set) else $error("Resume not flagged");
  property p_k;
    force_remote_wakeup |=> drive_k;
  endproperty
  a_k: assert property (p_k) else $error("K not driven");
  property p_wait;
    bus_req && wait_r |=> !wait_r ##1 wait_r;
  endproperty
  a_wait: assert property (p_wait) else $error("Waitrequest timing");

  c_in_data: cover property (rsp_valid && rsp_kind == 3'(ueh_pkg::UEH_RSP_DATA));
  c_stall: cover property (rsp_valid && rsp_kind == 3'(ueh_pkg::UEH_RSP_STALL));
  c_clear: cover property (ep0_tx_done_flag ##1 !ep0_tx_done_flag);
  c_resume: cover property (res_set);
  c_set_clr: cover property (set_clr_hit != 8'h00);

endmodule // ueh_ctrl
`default_nettype wire

// ---- tb/ueh_host_model.sv ----
// Host and serial-engine model: issues tokens and reports handshakes
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side of the token link
module ueh_host_model (
  input wire logic clk_sys,
  input wire logic ack_on,
  input wire logic [3:0] ack_delay,
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_kind,
  output logic tok_valid,
  output logic [1:0] tok_kind,
  output logic [1:0] tok_ep,
  output logic tx_acked,
  output logic [1:0] tx_acked_ep,
  output logic rx_acked,
  output logic [1:0] rx_acked_ep
);
  logic [1:0] last_ep; // Endpoint of the token in flight
  logic [2:0] kind_q; // Reply being answered
  // Idle levels at time zero
  initial begin
    tok_valid = 1'b0;
    tok_kind = 2'h3;
    tok_ep = 2'h3;
    tx_acked = 1'b0;
    tx_acked_ep = 2'h3;
    rx_acked = 1'b0;
    rx_acked_ep = 2'h3;
  end
  // One token pulse; fields are inverted afterwards so stale values never pass
  task automatic send_token(input logic [1:0] k, input logic [1:0] e);
    @(posedge clk_sys);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_ep <= e;
    last_ep <= e;
    @(posedge clk_sys);
    tok_valid <= 1'b0;
    tok_kind <= ~k;
    tok_ep <= ~e;
  endtask
  // Host ACK of sent data, or engine report of an accepted OUT or SETUP
  // A muted host (ack_on low) never acknowledges, as a lost handshake would
  initial forever begin
    @(posedge clk_sys);
    if (rsp_valid === 1'b1 && ack_on === 1'b1 &&
        (rsp_kind == ueh_pkg::UEH_RSP_DATA || rsp_kind == ueh_pkg::UEH_RSP_ACK)) begin
      kind_q = rsp_kind;
      repeat (ack_delay) @(posedge clk_sys);
      if (kind_q == ueh_pkg::UEH_RSP_DATA) begin
        tx_acked <= 1'b1;
        tx_acked_ep <= last_ep;
      end else begin
        rx_acked <= 1'b1;
        rx_acked_ep <= last_ep;
      end
      @(posedge clk_sys);
      tx_acked <= 1'b0;
      rx_acked <= 1'b0;
      tx_acked_ep <= ~last_ep;
      rx_acked_ep <= ~last_ep;
    end
  end
endmodule // ueh_host_model
`default_nettype wire

// ---- tb/ueh_ctrl_tb.sv ----
// Self-checking bench for the endpoint handshake block
`timescale 1ns/1ps
`default_nettype none
`include "ueh_consts.svh"
// ==========================================
// Bench top
module ueh_ctrl_tb;
  localparam logic [4:0] C0 = `UEH_OFS_CTRL0;
  localparam logic [4:0] C1 = `UEH_OFS_CTRL1;
  localparam logic [4:0] CL = `UEH_OFS_CLR;
  localparam logic [4:0] FL = `UEH_OFS_FLAGS;
  localparam logic [1:0] T_OUT = 2'h0;
  localparam logic [1:0] T_IN = 2'h1;
  localparam logic [1:0] T_SU = 2'h2;
  localparam logic [7:0] DAT = {5'h0, ueh_pkg::UEH_RSP_DATA};
  localparam logic [7:0] ACK = {5'h0, ueh_pkg::UEH_RSP_ACK};
  localparam logic [7:0] NAK = {5'h0, ueh_pkg::UEH_RSP_NAK};
  localparam logic [7:0] STL = {5'h0, ueh_pkg::UEH_RSP_STALL};
  localparam logic [7:0] NON = {5'h0, ueh_pkg::UEH_RSP_NONE};
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic tok_valid, tx_acked, rx_acked;
  logic [1:0] tok_kind, tok_ep, tx_acked_ep, rx_acked_ep;
  logic eop_seen = 1'b0;
  logic bus_reset_seen = 1'b0;
  logic bus_activity = 1'b0;
  logic ep1_active = 1'b0;
  logic ep2_tx_enable = 1'b0;
  logic ep2_rx_enable = 1'b0;
  logic ep2_tx_data_toggle = 1'b0;
  logic [3:0] ep2_tx_byte_count = 4'h0;
  logic suspend_request = 1'b0;
  logic rsp_valid, rsp_toggle, drive_k, xcvr_low_power;
  logic [2:0] rsp_kind;
  logic [3:0] rsp_count;
  logic ack_on = 1'b1; // Host acknowledges sent data
  logic [3:0] ack_delay = 4'h1; // Host reply latency in cycles
  int bad_count = 0;
  int checks_done = 0;
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  ueh_ctrl dut_u (.clk_sys, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tok_valid, .tok_kind, .tok_ep, .tx_acked,
    .tx_acked_ep, .rx_acked, .rx_acked_ep, .eop_seen, .bus_reset_seen, .bus_activity,
    .ep1_active, .ep2_tx_enable, .ep2_rx_enable, .ep2_tx_data_toggle, .ep2_tx_byte_count,
    .suspend_request, .rsp_valid, .rsp_kind, .rsp_toggle, .rsp_count, .drive_k,
    .xcvr_low_power);
  ueh_host_model host_u (.clk_sys, .ack_on, .ack_delay, .rsp_valid, .rsp_kind, .tok_valid,
    .tok_kind, .tok_ep, .tx_acked, .tx_acked_ep, .rx_acked, .rx_acked_ep);
  // ==========================================
  // Shared helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Avalon transfer held until waitrequest is sampled low; bounded wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
      bad_count++;
      tally_and_finish();
    end else begin
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string what, input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, exp, q);
  endtask
  // Token and its reply, which stands one cycle after the token
  task automatic tk(input logic [1:0] k, input logic [1:0] e, input logic [7:0] exp);
    host_u.send_token(k, e);
    @(posedge clk_sys);
    chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
    chk("rsp_kind", exp, {5'h0, rsp_kind});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    rd("ctrl0 reset", C0, 8'h00);
    rd("ctrl1 reset", C1, 8'h00);
    rd("flags reset", FL, 8'h00);
    rd("unmapped", 5'h04, 8'h00);
    wr(C0, 8'hff);
    rd("ctrl0", C0, 8'hbf);
    wr(C1, 8'hef);
    rd("ctrl1", C1, 8'hef);
    wr(FL, 8'hff);
    rd("flags write", FL, 8'h00);
    wr(CL, 8'hff);
    rd("clear reg", CL, 8'h00);
    wr(C0, 8'h00);
    wr(C1, 8'h00);
  endtask
  task automatic t_ep0_in;
    tk(T_IN, 2'h0, NAK);
    wr(C0, 8'ha5);
    ack_on <= 1'b0;
    tk(T_IN, 2'h0, DAT);
    chk("rsp_toggle", 8'h01, {7'h0, rsp_toggle});
    chk("rsp_count", 8'h05, {4'h0, rsp_count});
    idle(8);
    rd("no ack flag", FL, 8'h00);
    ack_on <= 1'b1;
    ack_delay <= 4'h5;
    wr(C0, 8'h23);
    tk(T_IN, 2'h0, DAT);
    chk("rsp_toggle", 8'h00, {7'h0, rsp_toggle});
    chk("rsp_count", 8'h03, {4'h0, rsp_count});
    idle(8);
    rd("ep0 tx flag", FL, 8'h02);
    tk(T_IN, 2'h0, NAK);
    wr(CL, 8'h00);
    rd("zero clear", FL, 8'h02);
    wr(CL, 8'h02);
    rd("ep0 tx clear", FL, 8'h00);
    ack_delay <= 4'h1;
    wr(C0, 8'h00);
  endtask
  task automatic t_ep0_out;
    wr(C0, 8'h10);
    tk(T_OUT, 2'h0, ACK);
    idle(3);
    rd("ep0 rx flag", FL, 8'h01);
    tk(T_OUT, 2'h0, NAK);
    tk(T_SU, 2'h0, ACK);
    wr(CL, 8'h01);
    tk(T_OUT, 2'h0, ACK);
    wr(C0, 8'h00);
    tk(T_OUT, 2'h0, NAK);
    tk(T_SU, 2'h0, ACK);
    wr(CL, 8'hff);
  endtask
  task automatic t_ep2;
    @(posedge clk_sys);
    ep2_rx_enable <= 1'b1;
    tk(T_OUT, 2'h2, ACK);
    idle(3);
    rd("ep2 rx flag", FL, 8'h10);
    tk(T_OUT, 2'h2, NAK);
    wr(CL, 8'h10);
    ep2_rx_enable <= 1'b0;
    tk(T_OUT, 2'h2, NAK);
    ep2_tx_enable <= 1'b1;
    ep2_tx_data_toggle <= 1'b1;
    ep2_tx_byte_count <= 4'h9;
    tk(T_IN, 2'h2, DAT);
    chk("rsp_toggle", 8'h01, {7'h0, rsp_toggle});
    chk("rsp_count", 8'h09, {4'h0, rsp_count});
    idle(4);
    rd("ep2 tx flag", FL, 8'h20);
    tk(T_IN, 2'h2, NAK);
    ep2_tx_enable <= 1'b0;
    wr(CL, 8'hff);
  endtask
  task automatic t_ep1;
    wr(C1, 8'h40);
    tk(T_IN, 2'h1, STL);
    tk(T_OUT, 2'h1, STL);
    tk(2'h3, 2'h1, NON);
    ep1_active <= 1'b1;
    wr(C1, 8'ha7);
    tk(T_IN, 2'h1, DAT);
    chk("rsp_toggle", 8'h01, {7'h0, rsp_toggle});
    chk("rsp_count", 8'h07, {4'h0, rsp_count});
    idle(4);
    rd("ep1 tx flag", FL, 8'h08);
    tk(T_IN, 2'h3, NON);
    tk(T_IN, 2'h1, NAK);
    wr(CL, 8'h08);
    wr(C1, 8'h00);
    tk(T_IN, 2'h1, NAK);
    tk(T_OUT, 2'h1, NON);
    ep1_active <= 1'b0;
  endtask
  task automatic t_resume;
    @(posedge clk_sys);
    suspend_request <= 1'b1;
    bus_activity <= 1'b1;
    @(posedge clk_sys);
    bus_activity <= 1'b0;
    idle(2);
    chk("xcvr_low_power", 8'h01, {7'h0, xcvr_low_power});
    rd("resume flag", FL, 8'h04);
    wr(CL, 8'h04);
    rd("resume clear", FL, 8'h00);
    wr(C1, 8'h10);
    idle(2);
    chk("drive_k", 8'h01, {7'h0, drive_k});
    bus_activity <= 1'b1;
    @(posedge clk_sys);
    bus_activity <= 1'b0;
    idle(2);
    rd("forced resume", FL, 8'h00);
    wr(C1, 8'h00);
    idle(2);
    chk("drive_k off", 8'h00, {7'h0, drive_k});
    suspend_request <= 1'b0;
    idle(2);
    chk("xcvr_low_power off", 8'h00, {7'h0, xcvr_low_power});
  endtask
  // End-of-packet held high across the clearing write, so both meet at one edge
  task automatic t_race;
    @(posedge clk_sys);
    bus_reset_seen <= 1'b1;
    eop_seen <= 1'b1;
    @(posedge clk_sys);
    bus_reset_seen <= 1'b0;
    rd("eop and bus reset", FL, 8'hc0);
    wr(CL, 8'hc0);
    eop_seen <= 1'b0;
    rd("set beats clear", FL, 8'h80);
    wr(CL, 8'h80);
    rd("eop clear", FL, 8'h00);
  endtask
  task automatic t_rerun;
    wr(C0, 8'hb3);
    eop_seen <= 1'b1;
    @(posedge clk_sys);
    eop_seen <= 1'b0;
    arst_n <= 1'b0;
    idle(2);
    arst_n <= 1'b1;
    idle(3);
    rd("ctrl0 after reset", C0, 8'h00);
    rd("flags after reset", FL, 8'h00);
  endtask
  // ==========================================
  // Verdict and main sequence
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    idle(6);
    arst_n <= 1'b1;
    idle(3);
    t_regs();
    t_ep0_in();
    t_ep0_out();
    t_ep2();
    t_ep1();
    t_resume();
    t_race();
    t_rerun();
    tally_and_finish();
  end
endmodule // ueh_ctrl_tb
`default_nettype wire
